// File: hw/plm_link_ctrl.sv
// Overview of operation
// - Resolve speed, duplex, master from both advertisements.
// - Without partner negotiation, use parallel detection.
// - Negotiation off: speed and duplex bits decide.
// - Gigabit link only through negotiation or the test enable.
// - Test enable plus speed 10b forces gigabit.
// - Correct crossed wiring at all three speeds.
// - Detect and correct inverted pair polarity.
// - Both corrections on after reset, disable bits.
// - Four pair mappings including C/D swap.
// - Force field 10b MDI, 11b MDI-X.
// - Force 00b: choice follows two disable bits.
// - After failed gigabit attempts, drop gigabit advertisement.
// - Gigabit restored for later capable partner.
// - Two-pair cable downshifts to 10/100.
// - Low power idle only at 100/1000.
// - Enable bit selects reduced-amplitude 10 Mb/s.
// - Trigger bit starts the cable test.
// - Gigabit link survives diagnostics.
// - 10/100 link drops during test, then returns.
// - Flag bad termination, opens and shorts.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module plm_link_ctrl
  import plm_pkg::*;
#(
  parameter int LINK_FAIL_CYC = LINK_FAIL_CYC_DEF
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  input  wire logic        PARTNER_ANEG_VALID,
  input  wire logic [5:0]  PARTNER_ADV,
  input  wire logic [9:0]  PARTNER_SEED,
  input  wire logic [2:0]  PARTNER_EEE_ADV,
  input  wire logic        PD_VALID,
  input  wire logic [1:0]  PD_SPEED,
  input  wire logic        LINK_OK,
  input  wire logic        PAIR_CD_PRESENT,
  input  wire logic [1:0]  PAIR_MAP,
  input  wire logic [3:0]  PAIR_INVERT,
  input  wire logic        DIAG_ACK,
  input  wire logic [7:0]  DIAG_OHMS,
  input  wire logic        DIAG_COUPLED,
  input  wire logic [7:0]  DIAG_LEN,
  output logic             LINK_UP,
  output logic      [1:0]  SPEED,
  output logic             FULL_DUPLEX,
  output logic             MASTER,
  output logic      [5:0]  ADV_OUT,
  output logic             MDIX,
  output logic             SWAP_CD,
  output logic      [3:0]  POL_CORRECT,
  output logic             LPI_ALLOWED,
  output logic             TE10_MODE,
  output logic             DIAG_REQ,
  output logic      [1:0]  DIAG_PAIR
);

  typedef struct packed {
    logic [15:0] mode;
    logic [5:0]  adv;
    logic [15:0] byp;
    logic [15:0] xov;
    logic [15:0] ext3;
    logic [15:0] eeec;
    logic [2:0]  eee_adv;
    logic        trig;
    logic        done;
    logic [11:0] res;
    logic [7:0]  len;
    logic [15:0] rdata;
    plm_link_e   lst;
    logic [1:0]  spd;
    logic        fdx;
    logic        master;
    logic        by_aneg;
    logic [15:0] timer;
    logic [2:0]  fails;
    logic        dshift;
    plm_diag_e   dst;
    logic [1:0]  dpair;
    logic        hold;
    logic [9:0]  seed;
  } plm_state_s;

  plm_state_s s;
  plm_state_s n;

  // Highest common ability: valid, speed, full duplex.
  function automatic logic [3:0] plm_hcd(input logic [5:0] loc, input logic [5:0] par,
                                         input logic no_gig);
    logic [5:0] c;
    c = loc & par;
    if (no_gig) begin
      c[ADV_1000FD] = 1'b0;
    end
    if (c[ADV_1000FD]) begin
      plm_hcd = {1'b1, SPD_1000, 1'b1};
    end else if (c[ADV_100FD]) begin
      plm_hcd = {1'b1, SPD_100, 1'b1};
    end else if (c[ADV_100HD]) begin
      plm_hcd = {1'b1, SPD_100, 1'b0};
    end else if (c[ADV_10FD]) begin
      plm_hcd = {1'b1, SPD_10, 1'b1};
    end else if (c[ADV_10HD]) begin
      plm_hcd = {1'b1, SPD_10, 1'b0};
    end else begin
      plm_hcd = 4'h0;
    end
  endfunction

  // Role resolution: a sole preference wins, otherwise the larger seed is master.
  function automatic logic plm_master(input logic lp, input logic pp, input logic [9:0] ls,
                                      input logic [9:0] ps);
    if (lp != pp) begin
      plm_master = lp;
    end else begin
      plm_master = ls > ps;
    end
  endfunction

  logic       aneg_en;
  logic [1:0] frc_spd;
  logic [1:0] xov_frc;
  logic       auto_x;
  logic [2:0] ds_limit;
  logic [3:0] hcd;
  logic       two_pair;

  assign aneg_en  = s.mode[MODE_ANEG_EN];
  assign frc_spd  = {s.mode[MODE_SPD1], s.mode[MODE_SPD0]};
  assign xov_frc  = s.xov[XOV_FRC_LO +: 2];
  assign ds_limit = {1'b0, s.ext3[EXT_CNT_LO +: 2]} + 3'h2;
  // Missing C/D pairs rule out gigabit before resolution, not one attempt later.
  assign two_pair = aneg_en && s.ext3[EXT_IMPAIR] && !PAIR_CD_PRESENT;
  assign hcd      = plm_hcd(s.adv, PARTNER_ADV, s.dshift || two_pair);

  // Crossover choice: force field first, then the two disable bits, else detection.
  always_comb begin
    auto_x = 1'b0;
    if (xov_frc == XOV_MDI) begin
      auto_x = 1'b0;
    end else if (xov_frc == XOV_MDIX) begin
      auto_x = 1'b0;
    // Disable bits decide when not forced.
    end else if (s.byp[BYP_DIS_MDIX]) begin
      auto_x = 1'b0;
    end else if (s.byp[BYP_DIS_MDXF] && !aneg_en && frc_spd != SPD_1000) begin
      auto_x = 1'b0;
    end else begin
      auto_x = 1'b1;
    end
  end

  assign MDIX        = (xov_frc == XOV_MDIX) || (auto_x && PAIR_MAP[0]);
  // C/D pair swap is the second mapping bit.
  assign SWAP_CD     = auto_x && PAIR_MAP[1];
  assign POL_CORRECT = s.byp[BYP_DIS_POL] ? 4'h0 : PAIR_INVERT;
  assign LINK_UP     = s.lst == LS_UP;
  assign SPEED       = s.spd;
  assign FULL_DUPLEX = s.fdx;
  assign MASTER      = s.master;
  // Gigabit withdrawn from the advertisement while downshifted.
  assign ADV_OUT     = s.dshift ? (s.adv & ~(6'h1 << ADV_1000FD)) : s.adv;
  // Low power idle only at 100 or 1000 with both sides able.
  assign LPI_ALLOWED = LINK_UP && s.fdx &&
                       ((s.spd == SPD_100 && s.eee_adv[EEE_AB_100] && PARTNER_EEE_ADV[EEE_AB_100])
                     || (s.spd == SPD_1000 && s.eee_adv[EEE_AB_1000]
                         && PARTNER_EEE_ADV[EEE_AB_1000]));
  assign TE10_MODE   = s.eeec[EEE_TE10] && s.spd == SPD_10;
  assign DIAG_REQ    = s.dst == DG_REQ;
  assign DIAG_PAIR   = s.dpair;
  assign RDATA       = s.rdata;

  // Next-state logic for registers, link sequencer and diagnostics.
  always_comb begin
    logic [2:0] code;
    code = DR_OK;
    n = s;
    n.rdata = 16'h0000;
    n.seed = {s.seed[8:0], s.seed[9] ^ s.seed[6]};

    // Software writes; a mode write also restarts link bring-up.
    if (WR) begin
      case (ADDR)
        ADR_MODE_CTRL: begin
          n.mode = WDATA;
          n.mode[MODE_RESTART] = 1'b0;
          n.lst = LS_NEG;
        end
        ADR_LOC_ADV: n.adv = WDATA[5:0];
        ADR_BYPASS: n.byp = WDATA;
        ADR_XOVER: n.xov = WDATA;
        ADR_EXT_CTRL3: n.ext3 = WDATA;
        ADR_EEE_CTRL: n.eeec = WDATA;
        ADR_EEE_ADV: n.eee_adv = WDATA[2:0];
        ADR_DIAG_CTRL: begin
          if (WDATA[DIAG_TRIG] && s.dst == DG_IDLE) begin
            n.trig = 1'b1;
            n.done = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Registered read answer, zero for unmapped addresses.
    if (RD) begin
      case (ADDR)
        ADR_MODE_CTRL: n.rdata = s.mode;
        ADR_MODE_STAT: begin
          n.rdata[ST_LINK] = LINK_UP;
          n.rdata[ST_ANEG_DONE] = LINK_UP && s.by_aneg;
          n.rdata[ST_SPD_LO +: 2] = s.spd;
          n.rdata[ST_FDX] = s.fdx;
          n.rdata[ST_MASTER] = s.master;
        end
        ADR_LOC_ADV: n.rdata = {10'h000, s.adv};
        ADR_PAR_ADV: n.rdata = {10'h000, PARTNER_ADV};
        ADR_BYPASS: n.rdata = s.byp;
        ADR_AUX_STAT: begin
          n.rdata[AUX_MDIX] = MDIX;
          n.rdata[AUX_SWAP_CD] = SWAP_CD;
          n.rdata[AUX_POL_LO +: 4] = POL_CORRECT;
          n.rdata[AUX_DSHIFT] = s.dshift;
          n.rdata[AUX_LPI] = LPI_ALLOWED;
        end
        ADR_XOVER: n.rdata = s.xov;
        ADR_EXT_CTRL3: n.rdata = s.ext3;
        ADR_EEE_CTRL: n.rdata = s.eeec;
        ADR_EEE_ADV: n.rdata = {13'h0000, s.eee_adv};
        ADR_EEE_PAR: n.rdata = {13'h0000, PARTNER_EEE_ADV};
        ADR_DIAG_CTRL: n.rdata = {s.trig, s.done, 14'h0000};
        ADR_DIAG_RES: n.rdata = {4'h0, s.res};
        ADR_DIAG_LEN: n.rdata = {8'h00, s.len};
        default: n.rdata = 16'h0000;
      endcase
    end

    // Link bring-up sequencer.
    if (!(WR && ADDR == ADR_MODE_CTRL)) begin
      case (s.lst)
        LS_NEG: begin
          n.timer = 16'h0000;
          // Missing C/D pairs force a downshift.
          if (two_pair) begin
            n.dshift = 1'b1;
          end
          if (!aneg_en) begin
            n.by_aneg = 1'b0;
            n.fdx = s.mode[MODE_DUPLEX];
            n.spd = (frc_spd == SPD_100) ? SPD_100 : SPD_10;
            if (frc_spd == SPD_1000) begin
              // Test mode forces gigabit with resolved role.
              if (s.eeec[EEE_FRC1000]) begin
                n.spd = SPD_1000;
                n.fdx = 1'b1;
                n.master = plm_master(1'b0, 1'b0, s.seed, PARTNER_SEED);
                n.lst = LS_WAIT;
              end
            end else begin
              n.lst = LS_WAIT;
            end
          end else if (PARTNER_ANEG_VALID) begin
            if (hcd[3]) begin
              n.by_aneg = 1'b1;
              n.spd = hcd[2:1];
              n.fdx = hcd[0];
              n.master = plm_master(s.adv[ADV_MS_PREF], PARTNER_ADV[ADV_MS_PREF],
                                    s.seed, PARTNER_SEED);
              n.lst = LS_WAIT;
            end
          // Parallel detection of a non-negotiating partner.
          end else if (PD_VALID) begin
            n.by_aneg = 1'b0;
            n.spd = (PD_SPEED == SPD_100) ? SPD_100 : SPD_10;
            n.fdx = 1'b0;
            n.lst = LS_WAIT;
          end
        end
        LS_WAIT: begin
          n.timer = s.timer + 16'h0001;
          if (LINK_OK) begin
            n.lst = LS_UP;
            n.fails = 3'h0;
          end else if (s.timer == 16'(LINK_FAIL_CYC - 1)) begin
            n.lst = LS_NEG;
            if (s.by_aneg && s.spd == SPD_1000 && s.ext3[EXT_APPLY]) begin
              if (s.fails + 3'h1 >= ds_limit) begin
                n.dshift = 1'b1;
                n.fails = 3'h0;
              end else begin
                n.fails = s.fails + 3'h1;
              end
            end
          end
        end
        LS_UP: begin
          if (s.hold) begin
            n.lst = LS_HOLD;
          end else if (!LINK_OK) begin
            // Link loss re-arms gigabit for the next partner.
            n.lst = LS_NEG;
            n.dshift = 1'b0;
          end
        end
        LS_HOLD: begin
          if (!s.hold) begin
            n.lst = LS_NEG;
          end
        end
        default: n.lst = LS_NEG;
      endcase
    end

    // Cable diagnostics sequencer, one pair at a time.
    case (s.dst)
      DG_IDLE: begin
        if (s.trig) begin
          // Only a 10/100 link is held down.
          n.hold = s.lst == LS_UP && s.spd != SPD_1000;
          n.dpair = 2'h0;
          n.dst = DG_REQ;
        end
      end
      DG_REQ: n.dst = DG_WAIT;
      DG_WAIT: begin
        if (DIAG_ACK) begin
          // Classify coupling, short, open and termination window.
          if (DIAG_COUPLED) begin
            code = DR_COUPLE;
          end else if (DIAG_OHMS <= OHM_SHORT) begin
            code = DR_SHORT;
          end else if (DIAG_OHMS >= OHM_OPEN) begin
            code = DR_OPEN;
          end else if (DIAG_OHMS > OHM_MAX || DIAG_OHMS < OHM_MIN) begin
            code = DR_ANOM;
          end
          n.res[3 * s.dpair +: 3] = code;
          if (s.dpair == 2'h0) begin
            n.len = DIAG_LEN;
          end
          if (s.dpair == 2'h3) begin
            n.dst = DG_END;
          end else begin
            n.dpair = s.dpair + 2'h1;
            n.dst = DG_REQ;
          end
        end
      end
      DG_END: begin
        n.trig = 1'b0;
        n.done = 1'b1;
        n.hold = 1'b0;
        n.dst = DG_IDLE;
      end
      default: n.dst = DG_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
      s.mode <= MODE_CTRL_RST;
      s.adv <= LOC_ADV_RST[5:0];
      // Both corrections enabled out of reset.
      s.byp <= BYPASS_RST;
      s.xov <= XOVER_RST;
      s.ext3 <= EXT_CTRL3_RST;
      s.eeec <= EEE_CTRL_RST;
      s.eee_adv <= EEE_ADV_RST[2:0];
      s.seed <= SEED_RST;
      s.lst <= LS_NEG;
      s.dst <= DG_IDLE;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // Gigabit survives diagnostics; a mode write may still restart the link.
  a_diag_gig_keep: assert property (
    (s.dst != DG_IDLE && LINK_UP && s.spd == SPD_1000 && LINK_OK && !WR) |=> LINK_UP)
    else $error("gigabit link dropped by diagnostics");
  // Slow link held down from the cycle after the hold is taken.
  a_diag_hold_down: assert property (s.hold |=> !LINK_UP)
    else $error("link up while held for diagnostics");
  a_forced_gig_test: assert property (
    (LINK_UP && !s.by_aneg && SPEED == SPD_1000) |-> s.eeec[EEE_FRC1000])
    else $error("forced gigabit without test enable");
  a_xover_force: assert property (
    (xov_frc == XOV_MDI |-> !MDIX && !SWAP_CD) and (xov_frc == XOV_MDIX |-> MDIX))
    else $error("crossover force ignored");
  a_pol_disable: assert property (s.byp[BYP_DIS_POL] |-> POL_CORRECT == 4'h0)
    else $error("polarity corrected while disabled");
  a_lpi_speed: assert property (LPI_ALLOWED |-> SPEED != SPD_10 && FULL_DUPLEX)
    else $error("low power idle at wrong speed");
  // Trigger leads to first pair request two cycles later.
  a_diag_start: assert property (
    (WR && ADDR == ADR_DIAG_CTRL && WDATA[DIAG_TRIG] && s.dst == DG_IDLE && !s.trig)
    |-> ##2 (DIAG_REQ && DIAG_PAIR == 2'h0))
    else $error("diagnostics did not start");
  a_dshift_adv: assert property ($rose(s.dshift) |-> !ADV_OUT[ADV_1000FD] [*2])
    else $error("gigabit advertised after downshift");
  // Parallel detection yields half duplex at detected speed.
  a_pdet_half: assert property (
    (s.lst == LS_NEG && aneg_en && !PARTNER_ANEG_VALID && PD_VALID && !WR)
    |=> (!FULL_DUPLEX && SPEED == $past(PD_SPEED) && s.lst == LS_WAIT))
    else $error("parallel detection result wrong");
  a_term_window: assert property (
    (s.dst == DG_WAIT && DIAG_ACK && !DIAG_COUPLED && DIAG_OHMS > OHM_MAX
     && DIAG_OHMS < OHM_OPEN) |=> s.res[3 * $past(s.dpair) +: 3] == DR_ANOM)
    else $error("anomalous termination not flagged");

  c_gig_aneg: cover property (LINK_UP && s.by_aneg && SPEED == SPD_1000);
  c_downshift: cover property ($rose(s.dshift));
  c_diag_done: cover property ($rose(s.done));
  c_pdet_link: cover property (LINK_UP && !s.by_aneg && aneg_en);

endmodule
`default_nettype wire

// File: hw/plm_pkg.sv
package plm_pkg;
  // Clock rate and the time allowed for a resolved link to come up.
  localparam int CLK_HZ            = 40_000_000;
  localparam int LINK_FAIL_US      = 1000;
  localparam int LINK_FAIL_CYC_DEF = LINK_FAIL_US * (CLK_HZ / 1_000_000);

  // Register addresses on the management port.
  localparam logic [3:0] ADR_MODE_CTRL = 4'h0;
  localparam logic [3:0] ADR_MODE_STAT = 4'h1;
  localparam logic [3:0] ADR_LOC_ADV   = 4'h2;
  localparam logic [3:0] ADR_PAR_ADV   = 4'h3;
  localparam logic [3:0] ADR_BYPASS    = 4'h4;
  localparam logic [3:0] ADR_AUX_STAT  = 4'h5;
  localparam logic [3:0] ADR_XOVER     = 4'h6;
  localparam logic [3:0] ADR_EXT_CTRL3 = 4'h7;
  localparam logic [3:0] ADR_EEE_CTRL  = 4'h8;
  localparam logic [3:0] ADR_EEE_ADV   = 4'h9;
  localparam logic [3:0] ADR_EEE_PAR   = 4'hA;
  localparam logic [3:0] ADR_DIAG_CTRL = 4'hB;
  localparam logic [3:0] ADR_DIAG_RES  = 4'hC;
  localparam logic [3:0] ADR_DIAG_LEN  = 4'hD;

  // Field positions.
  localparam int MODE_SPD1    = 6;
  localparam int MODE_DUPLEX  = 8;
  localparam int MODE_RESTART = 9;
  localparam int MODE_ANEG_EN = 12;
  localparam int MODE_SPD0    = 13;
  localparam int ST_LINK      = 0;
  localparam int ST_ANEG_DONE = 1;
  localparam int ST_SPD_LO    = 2;
  localparam int ST_FDX       = 4;
  localparam int ST_MASTER    = 5;
  localparam int ADV_10HD     = 0;
  localparam int ADV_10FD     = 1;
  localparam int ADV_100HD    = 2;
  localparam int ADV_100FD    = 3;
  localparam int ADV_1000FD   = 4;
  localparam int ADV_MS_PREF  = 5;
  localparam int BYP_DIS_POL  = 4;
  localparam int BYP_DIS_MDIX = 5;
  localparam int BYP_DIS_MDXF = 7;
  localparam int AUX_MDIX     = 0;
  localparam int AUX_SWAP_CD  = 1;
  localparam int AUX_POL_LO   = 2;
  localparam int AUX_DSHIFT   = 6;
  localparam int AUX_LPI      = 7;
  localparam int XOV_FRC_LO   = 2;
  localparam int EXT_APPLY    = 1;
  localparam int EXT_CNT_LO   = 2;
  localparam int EXT_IMPAIR   = 4;
  localparam int EEE_FRC1000  = 5;
  localparam int EEE_TE10     = 8;
  localparam int EEE_AB_100   = 1;
  localparam int EEE_AB_1000  = 2;
  localparam int DIAG_DONE    = 14;
  localparam int DIAG_TRIG    = 15;

  // Reset values.
  localparam logic [15:0] MODE_CTRL_RST = 16'h1140;
  localparam logic [15:0] LOC_ADV_RST   = 16'h001F;
  localparam logic [15:0] BYPASS_RST    = 16'h0000;
  localparam logic [15:0] XOVER_RST     = 16'h0000;
  localparam logic [15:0] EXT_CTRL3_RST = 16'h0000;
  localparam logic [15:0] EEE_CTRL_RST  = 16'h0000;
  localparam logic [15:0] EEE_ADV_RST   = 16'h0006;
  localparam logic [9:0]  SEED_RST      = 10'h2A5;

  // Speed codes, crossover force codes and termination window in ohms.
  localparam logic [1:0] SPD_10    = 2'h0;
  localparam logic [1:0] SPD_100   = 2'h1;
  localparam logic [1:0] SPD_1000  = 2'h2;
  localparam logic [1:0] XOV_MDI   = 2'h2;
  localparam logic [1:0] XOV_MDIX  = 2'h3;
  localparam logic [7:0] OHM_MAX   = 8'd115;
  localparam logic [7:0] OHM_MIN   = 8'd85;
  localparam logic [7:0] OHM_SHORT = 8'd10;
  localparam logic [7:0] OHM_OPEN  = 8'd250;

  // Per-pair diagnostic result codes.
  localparam logic [2:0] DR_OK     = 3'h0;
  localparam logic [2:0] DR_OPEN   = 3'h1;
  localparam logic [2:0] DR_SHORT  = 3'h2;
  localparam logic [2:0] DR_ANOM   = 3'h3;
  localparam logic [2:0] DR_COUPLE = 3'h4;

  typedef enum logic [1:0] {LS_NEG, LS_WAIT, LS_UP, LS_HOLD} plm_link_e;
  typedef enum logic [1:0] {DG_IDLE, DG_REQ, DG_WAIT, DG_END} plm_diag_e;
endpackage

// File: tb/phy_link_mode_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module phy_link_mode_control_test
  import plm_pkg::*;
;
  logic        clk_sys = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, an_valid = 1'b0;
  logic        pd_valid = 1'b0, cd_here = 1'b1, link_en = 1'b0;
  logic [3:0]  addr = 4'h0, pair_inv = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [5:0]  p_adv = 6'h00, adv_out;
  logic [2:0]  p_eee = 3'h6;
  logic [1:0]  pd_speed = 2'h0, pair_map = 2'h0, speed, dpair;
  logic [7:0]  ohms, dlen;
  logic        link_ok, dack, dcoup, dreq, link_up, fdx, master, mdix, swap_cd, lpi, te10;
  logic [3:0]  pol;
  int          fail_count = 0;
  int          total_checks = 0;

  // Clock at 40 MHz.
  always #12.5 clk_sys = ~clk_sys;

  plm_link_ctrl #(.LINK_FAIL_CYC(20)) plm_link_ctrl_i (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PARTNER_ANEG_VALID(an_valid), .PARTNER_ADV(p_adv),
    .PARTNER_SEED(10'h000), .PARTNER_EEE_ADV(p_eee), .PD_VALID(pd_valid),
    .PD_SPEED(pd_speed), .LINK_OK(link_ok), .PAIR_CD_PRESENT(cd_here), .PAIR_MAP(pair_map),
    .PAIR_INVERT(pair_inv), .DIAG_ACK(dack), .DIAG_OHMS(ohms), .DIAG_COUPLED(dcoup),
    .DIAG_LEN(dlen), .LINK_UP(link_up), .SPEED(speed), .FULL_DUPLEX(fdx), .MASTER(master),
    .ADV_OUT(adv_out), .MDIX(mdix), .SWAP_CD(swap_cd), .POL_CORRECT(pol),
    .LPI_ALLOWED(lpi), .TE10_MODE(te10), .DIAG_REQ(dreq), .DIAG_PAIR(dpair));

  plm_peer_model plm_peer_model_i (
    .clk(clk_sys), .rst_n(rst_n), .link_en(link_en), .diag_req(dreq), .diag_pair(dpair),
    .link_ok(link_ok), .diag_ack(dack), .diag_ohms(ohms), .diag_coupled(dcoup),
    .diag_len(dlen));

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Stand-in register access.
  // One-cycle register write and read; read data stand in the cycle after the strobe.
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    rd_reg(a, d);
    chk(d, exp, what);
  endtask

  // Waits a bounded time for the link to reach a level; running out ends the run.
  task automatic wait_link(input logic lvl);
    for (int n = 0; n < 300 && link_up !== lvl; n++) begin
      @(posedge clk_sys);
      #1;
    end
    if (link_up !== lvl) begin
      fail_count++;
      $display("wrong value at %0t: link level never reached", $time);
      complete_run();
    end
  endtask

  // Runs the cable test, watching whether the link drops meanwhile.
  task automatic run_diag(input logic drop_exp);
    logic [15:0] d;
    logic        dropped;
    dropped = 1'b0;
    d = 16'h0000;
    wr_reg(ADR_DIAG_CTRL, 16'h8000);
    for (int n = 0; n < 60 && d[DIAG_DONE] !== 1'b1; n++) begin
      rd_reg(ADR_DIAG_CTRL, d);
      if (link_up !== 1'b1) dropped = 1'b1;
    end
    chk({15'h0, dropped}, {15'h0, drop_exp}, "link drop");
    chk(d & 16'hC000, 16'h4000, "diag done");
    if (d[DIAG_DONE] !== 1'b1) complete_run();
    rd_chk(ADR_DIAG_RES, {4'h0, DR_ANOM, DR_SHORT, DR_OPEN, DR_OK}, "pair result");
    rd_chk(ADR_DIAG_LEN, 16'h002D, "length");
    wait_link(1'b1);
  endtask

  // Reset values and an unmapped read.
  task automatic test_reset();
    rd_chk(ADR_MODE_CTRL, MODE_CTRL_RST, "mode");
    rd_chk(ADR_LOC_ADV, LOC_ADV_RST, "adv");
    rd_chk(ADR_BYPASS, BYPASS_RST, "bypass");
    rd_chk(ADR_EEE_ADV, EEE_ADV_RST, "eee adv");
    rd_chk(4'hF, 16'h0000, "unmapped");
    chk({10'h0, adv_out}, 16'h001F, "adv out");
    $display("test_reset done");
  endtask

  // Negotiated gigabit on crossed, swapped, inverted wiring, then a test under link.
  task automatic test_aneg();
    pair_map <= 2'h3;
    pair_inv <= 4'h5;
    p_adv <= 6'h3F;
    an_valid <= 1'b1;
    link_en <= 1'b1;
    wait_link(1'b1);
    chk({14'h0, speed}, {14'h0, SPD_1000}, "speed");
    chk({14'h0, fdx, master}, 16'h0002, "duplex role");
    rd_chk(ADR_MODE_STAT, 16'h001B, "status");
    rd_chk(ADR_EEE_PAR, 16'h0006, "partner eee");
    rd_chk(ADR_AUX_STAT, 16'h0097, "aux");
    run_diag(1'b0);
    $display("test_aneg done");
  endtask

  // Forced 100 full duplex, test drops link; forced 10 with reduced amplitude.
  task automatic test_forced();
    wr_reg(ADR_MODE_CTRL, 16'h2100);
    wait_link(1'b0);
    wait_link(1'b1);
    chk({13'h0, speed, fdx}, {13'h0, SPD_100, 1'b1}, "forced 100");
    run_diag(1'b1);
    wr_reg(ADR_EEE_CTRL, 16'h0100);
    wr_reg(ADR_MODE_CTRL, 16'h0100);
    wait_link(1'b0);
    wait_link(1'b1);
    chk({12'h0, speed, lpi, te10}, {12'h0, SPD_10, 2'b01}, "forced 10");
    $display("test_forced done");
  endtask

  // Crossover force codes and the disable bits.
  task automatic test_xover();
    pair_map <= 2'h0;
    wr_reg(ADR_XOVER, 16'h000C);
    rd_chk(ADR_AUX_STAT, 16'h0015, "force mdix");
    pair_map <= 2'h1;
    wr_reg(ADR_XOVER, 16'h0008);
    rd_chk(ADR_AUX_STAT, 16'h0014, "force mdi");
    wr_reg(ADR_XOVER, 16'h0000);
    wr_reg(ADR_BYPASS, 16'h0010);
    rd_chk(ADR_AUX_STAT, 16'h0001, "auto, pol off");
    wr_reg(ADR_BYPASS, 16'h0030);
    rd_chk(ADR_AUX_STAT, 16'h0000, "auto off");
    wr_reg(ADR_BYPASS, 16'h0090);
    rd_chk(ADR_AUX_STAT, 16'h0000, "auto off in forced 10");
    $display("test_xover done");
  endtask

  // Forced gigabit only with the test enable.
  task automatic test_force_gig();
    wr_reg(ADR_EEE_CTRL, 16'h0000);
    wr_reg(ADR_MODE_CTRL, 16'h0140);
    repeat (60) @(posedge clk_sys);
    chk({15'h0, link_up}, 16'h0000, "no forced gig");
    wr_reg(ADR_EEE_CTRL, 16'h0020);
    wait_link(1'b1);
    chk({13'h0, speed, master}, {13'h0, SPD_1000, 1'b1}, "test gig");
    $display("test_force_gig done");
  endtask

  // Two-pair downshift, recovery on a new partner, then parallel detection.
  task automatic test_downshift();
    wr_reg(ADR_EXT_CTRL3, 16'h0010);
    cd_here <= 1'b0;
    wr_reg(ADR_MODE_CTRL, 16'h1140);
    wait_link(1'b0);
    wait_link(1'b1);
    chk({8'h0, speed, adv_out}, {8'h0, SPD_100, 6'h0F}, "downshift");
    wr_reg(ADR_EEE_CTRL, 16'h0000);
    link_en <= 1'b0;
    cd_here <= 1'b1;
    wait_link(1'b0);
    link_en <= 1'b1;
    wait_link(1'b1);
    chk({8'h0, speed, adv_out}, {8'h0, SPD_1000, 6'h1F}, "gig back");
    wr_reg(ADR_EXT_CTRL3, 16'h0002);
    link_en <= 1'b0;
    wait_link(1'b0);
    repeat (60) @(posedge clk_sys);
    link_en <= 1'b1;
    wait_link(1'b1);
    chk({8'h0, speed, adv_out}, {8'h0, SPD_100, 6'h0F}, "attempt downshift");
    an_valid <= 1'b0;
    pd_valid <= 1'b1;
    pd_speed <= SPD_100;
    wr_reg(ADR_MODE_CTRL, 16'h1140);
    wait_link(1'b0);
    wait_link(1'b1);
    chk({13'h0, speed, fdx}, {13'h0, SPD_100, 1'b0}, "parallel");
    $display("test_downshift done");
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_reset();
    test_aneg();
    test_forced();
    test_xover();
    test_force_gig();
    test_downshift();
    complete_run();
  end
endmodule
`default_nettype wire

// File: tb/plm_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module plm_peer_model
  import plm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       link_en,
  input  wire logic       diag_req,
  input  wire logic [1:0] diag_pair,
  output logic            link_ok,
  output logic            diag_ack,
  output logic      [7:0] diag_ohms,
  output logic            diag_coupled,
  output logic      [7:0] diag_len
);
  logic [1:0] cnt;

  // Link follows the far end one cycle late; a measurement answers four cycles after each request.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= 2'h0;
      diag_ack <= 1'b0;
      link_ok  <= 1'b0;
    end else begin
      link_ok  <= link_en;
      diag_ack <= (cnt == 2'h1);
      if (diag_req) begin
        cnt <= 2'h3;
      end else if (cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end
    end
  end

  // one fault on each of pairs 1 to 3
  // Pair 0 good, 1 open, 2 short, 3 just above the window; outside an answer the lines churn.
  assign diag_ohms = !diag_ack ? {4{cnt}} : (diag_pair == 2'h0) ? 8'h64 :
                     (diag_pair == 2'h1) ? OHM_OPEN : (diag_pair == 2'h2) ? OHM_SHORT :
                     OHM_MAX + 8'h01;
  assign diag_coupled = 1'b0;
  assign diag_len     = diag_ack ? 8'h2D : {4{~cnt}};
endmodule
`default_nettype wire
